// ### src/debug_trigger_regs.vh
/*
 Register map, field positions and mode codes of the debug trigger logic.
 Assumes a 32-bit APB slave with word-aligned registers.
*/
`ifndef DEBUG_TRIGGER_REGS_VH
`define DEBUG_TRIGGER_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_COMP_A 12'h000
`define OFF_COMP_B 12'h004
`define OFF_FIFO_DATA 12'h008
`define OFF_CONTROL 12'h00c
`define OFF_TRIGGER_CONTROL 12'h010
`define OFF_DEBUG_STATUS 12'h014

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_ENABLE 0
`define CTL_ARM 1
`define CTL_TAG 2
`define CTL_BREAKPOINT_REQUEST_ENABLE 3
`define CTL_RWA 4
`define CTL_COMP_A_DIRECTION_QUALIFY_ENABLE 5
`define CTL_RWB 6
`define CTL_COMP_B_DIRECTION_QUALIFY_ENABLE 7
`define CTL_RESET 8'h00

// ----------------------------------------------------------------
// Trigger control fields
// ----------------------------------------------------------------
`define TC_OPCODE_FETCH_TRIGGER_SELECT_BIT 7
`define TC_BEGIN_BIT 6
`define TC_MODE_HI 3
`define TC_MODE_LO 0
`define TC_RESET 8'h00
`define TC_WRITE_MASK 8'hcf

// ----------------------------------------------------------------
// Trigger mode codes
// ----------------------------------------------------------------
`define MODE_A_ONLY 4'h0
`define MODE_A_OR_B 4'h1
`define MODE_A_THEN_B 4'h2
`define MODE_EVENT_B 4'h3
`define MODE_A_THEN_EVENT_B 4'h4
`define MODE_A_AND_B_DATA 4'h5
`define MODE_A_AND_NOT_B_DATA 4'h6
`define MODE_INSIDE 4'h7
`define MODE_OUTSIDE 4'h8

// ----------------------------------------------------------------
// Sizes and CPU opcodes
// ----------------------------------------------------------------
`define FIFO_DEPTH 8
`define FIFO_PTR_W 3
`define FIFO_CNT_W 4
`define TRACK_DEPTH 4
`define TRACK_PTR_W 2
`define BACKGROUND_ENTRY_OPCODE 8'h82
`define SOFTWARE_INTERRUPT_OPCODE 8'h83

`endif

// ### src/opcode_tracker.v
/*
 Follows compare hits on opcode fetches through the instruction queue.
 Assumes fetch and execute pulses in queue order, and a flush on change of flow.
*/
`timescale 1ns/1ns
`default_nettype none
`include "debug_trigger_regs.vh"

module opcode_tracker (
   // Clock and reset
   input wire ref_clk,
   input wire arst_n,
   // Queue events
   input wire fetch,
   input wire hit,
   input wire execute,
   input wire flush,
   // Result
   output reg executed
);

   reg [`TRACK_DEPTH-1:0] marks;
   reg [`TRACK_PTR_W-1:0] wrPtr;
   reg [`TRACK_PTR_W-1:0] rdPtr;

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         marks <= {`TRACK_DEPTH{1'b0}};
         wrPtr <= {`TRACK_PTR_W{1'b0}};
         rdPtr <= {`TRACK_PTR_W{1'b0}};
         executed <= 1'b0;
      end else if (flush) begin
         marks <= {`TRACK_DEPTH{1'b0}};
         wrPtr <= {`TRACK_PTR_W{1'b0}};
         rdPtr <= {`TRACK_PTR_W{1'b0}};
         executed <= 1'b0;
      end else begin
         executed <= execute & marks[rdPtr];
         if (fetch) begin
            marks[wrPtr] <= hit;
            wrPtr <= wrPtr + 1'b1;
         end
         if (execute) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ### src/trace_fifo.v
/*
 Trace storage: eight 16-bit entries, linear or circular fill.
 Assumes the owner raises clear for one cycle at arming.
*/
`timescale 1ns/1ns
`default_nettype none
`include "debug_trigger_regs.vh"

module trace_fifo (
   // Clock and reset
   input wire ref_clk,
   input wire arst_n,
   // Fill side
   input wire clear,
   input wire push,
   input wire circular,
   input wire [15:0] din,
   // Drain side
   input wire pop,
   output wire [15:0] dout,
   output reg [`FIFO_CNT_W-1:0] count,
   output wire full
);

   reg [15:0] mem [0:`FIFO_DEPTH-1];
   reg [`FIFO_PTR_W-1:0] wrPtr;
   reg [`FIFO_PTR_W-1:0] rdPtr;
   wire empty;

   assign full = (count == `FIFO_DEPTH);
   assign empty = (count == {`FIFO_CNT_W{1'b0}});
   assign dout = mem[rdPtr];

   always @(posedge ref_clk) begin
      if (push && (!full || circular)) begin
         mem[wrPtr] <= din;
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr <= {`FIFO_PTR_W{1'b0}};
         rdPtr <= {`FIFO_PTR_W{1'b0}};
         count <= {`FIFO_CNT_W{1'b0}};
      end else if (clear) begin
         wrPtr <= {`FIFO_PTR_W{1'b0}};
         rdPtr <= {`FIFO_PTR_W{1'b0}};
         count <= {`FIFO_CNT_W{1'b0}};
      end else if (push && full && circular) begin
         // Oldest entry is dropped to keep the newest history
         wrPtr <= wrPtr + 1'b1;
         rdPtr <= rdPtr + 1'b1;
      end else if (push && !full) begin
         wrPtr <= wrPtr + 1'b1;
         count <= count + 1'b1;
      end else if (pop && !empty) begin
         rdPtr <= rdPtr + 1'b1;
         count <= count - 1'b1;
      end
   end

endmodule
`default_nettype wire

// ### src/debug_trigger_logic.v
/*
 Debug trigger and breakpoint logic: two comparators, nine trigger modes,
 trace control and CPU breakpoint requests, with APB registers.
 Assumes the CPU bus pulses busValid per bus cycle on ref_clk, and flags
 opcode fetch, execute and change of flow in the same domain.
*/
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "debug_trigger_regs.vh"

module debug_trigger_logic (
   // Clock and reset
   input wire ref_clk,
   input wire arst_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // CPU bus cycle
   input wire busValid,
   input wire busRead,
   input wire [15:0] busAddr,
   input wire [7:0] busData,
   input wire opcodeFetch,
   input wire changeOfFlow,
   // Instruction queue
   input wire execute,
   input wire instrDone,
   input wire [7:0] execOpcode,
   input wire backgroundModeEnable,
   // CPU requests
   output reg tagRequest,
   output reg forceRequest,
   output reg substituteValid,
   output reg [7:0] substituteOpcode,
   output reg breakPending,
   output reg runActive
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [15:0] compA;
   reg [15:0] compB;
   reg [7:0] control;
   reg [7:0] triggerControl;
   reg compAHit;
   reg compBHit;
   reg seqArmed;
   reg tagMark;
   reg forceLatch;

   wire [3:0] triggerMode = triggerControl[`TC_MODE_HI:`TC_MODE_LO];
   wire opcodeSelect = triggerControl[`TC_OPCODE_FETCH_TRIGGER_SELECT_BIT];
   wire enable = control[`CTL_ENABLE];
   wire eventOnly = (triggerMode == `MODE_EVENT_B) || (triggerMode == `MODE_A_THEN_EVENT_B);
   wire beginTrace = triggerControl[`TC_BEGIN_BIT] | eventOnly;
   wire fullMode = (triggerMode == `MODE_A_AND_B_DATA) || (triggerMode == `MODE_A_AND_NOT_B_DATA);

   // ----------------------------------------------------------------
   // Comparators
   // ----------------------------------------------------------------
   wire dirOkA = !control[`CTL_COMP_A_DIRECTION_QUALIFY_ENABLE] || (busRead == control[`CTL_RWA]);
   wire dirOkB = !control[`CTL_COMP_B_DIRECTION_QUALIFY_ENABLE] || (busRead == control[`CTL_RWB]);
   wire rawA = busValid && (busAddr == compA) && dirOkA;
   wire rawB = busValid && (busAddr == compB) && dirOkB;
   wire dataEq = (busData == compB[7:0]);
   wire execA;
   wire execB;

   opcode_tracker trackA (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .fetch(busValid & opcodeFetch),
      .hit(rawA),
      .execute(execute),
      .flush(changeOfFlow),
      .executed(execA)
   );

   opcode_tracker trackB (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .fetch(busValid & opcodeFetch),
      .hit(rawB),
      .execute(execute),
      .flush(changeOfFlow),
      .executed(execB)
   );

   wire matchA = opcodeSelect ? execA : rawA;
   wire matchB = opcodeSelect ? execB : rawB;
   wire geA = busValid && (busAddr >= compA) && dirOkA;
   wire leB = busValid && (busAddr <= compB) && dirOkB;

   // ----------------------------------------------------------------
   // Trigger mode decode
   // ----------------------------------------------------------------
   reg trigger;
   reg capture;
   always @* begin
      trigger = 1'b0;
      capture = 1'b0;
      case (triggerMode)
         `MODE_A_ONLY: trigger = matchA;
         `MODE_A_OR_B: trigger = matchA | matchB;
         `MODE_A_THEN_B: trigger = matchB & seqArmed;
         `MODE_EVENT_B: capture = rawB;
         `MODE_A_THEN_EVENT_B: capture = rawB & seqArmed;
         `MODE_A_AND_B_DATA: trigger = rawA & dataEq;
         `MODE_A_AND_NOT_B_DATA: trigger = rawA & !dataEq;
         `MODE_INSIDE: trigger = geA & leB;
         `MODE_OUTSIDE: trigger = busValid && ((busAddr < compA) || (busAddr > compB)) && dirOkA;
         default: trigger = 1'b0;
      endcase
   end

   // Full modes issue tag requests on the address match alone
   wire breakSource = (fullMode && control[`CTL_TAG]) ? rawA : (trigger | capture);

   // ----------------------------------------------------------------
   // Trace FIFO
   // ----------------------------------------------------------------
   reg traceStarted;
   wire [`FIFO_CNT_W-1:0] fifoCount;
   wire fifoFull;
   wire [15:0] fifoOut;
   wire apbAccess = psel && penable && pready;
   wire armWrite = apbAccess && pwrite && (paddr == `OFF_CONTROL);
   wire armStart = armWrite && pwdata[`CTL_ARM] && pwdata[`CTL_ENABLE];
   wire fifoPop = apbAccess && !pwrite && (paddr == `OFF_FIFO_DATA) && !runActive;
   wire recording = runActive && (beginTrace ? (traceStarted | trigger) : 1'b1);
   wire flowPush = recording && !eventOnly && busValid && changeOfFlow;
   wire dataPush = runActive && eventOnly && capture;
   wire [15:0] fifoIn = eventOnly ? {8'h00, busData} : busAddr;

   trace_fifo fifo (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clear(armStart),
      .push(flowPush | dataPush),
      .circular(!beginTrace),
      .din(fifoIn),
      .pop(fifoPop),
      .dout(fifoOut),
      .count(fifoCount),
      .full(fifoFull)
   );

   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   wire runEnd = beginTrace ? fifoFull : trigger;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         runActive <= 1'b0;
         traceStarted <= 1'b0;
         seqArmed <= 1'b0;
         compAHit <= 1'b0;
         compBHit <= 1'b0;
      end else if (armStart) begin
         runActive <= 1'b1;
         traceStarted <= 1'b0;
         seqArmed <= 1'b0;
         compAHit <= 1'b0;
         compBHit <= 1'b0;
      end else if (!enable || !control[`CTL_ARM]) begin
         runActive <= 1'b0;
      end else if (runActive) begin
         if (runEnd) begin
            runActive <= 1'b0;
         end
         if (trigger) begin
            traceStarted <= 1'b1;
         end
         if (matchA) begin
            seqArmed <= 1'b1;
            compAHit <= 1'b1;
         end
         if (matchB) begin
            compBHit <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Breakpoint requests
   // ----------------------------------------------------------------
   wire breakFire = runActive && control[`CTL_BREAKPOINT_REQUEST_ENABLE] && breakSource;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tagRequest <= 1'b0;
         forceRequest <= 1'b0;
         tagMark <= 1'b0;
         forceLatch <= 1'b0;
         substituteValid <= 1'b0;
         substituteOpcode <= 8'h00;
         breakPending <= 1'b0;
      end else begin
         tagRequest <= breakFire && control[`CTL_TAG];
         forceRequest <= breakFire && !control[`CTL_TAG];
         if (breakFire && control[`CTL_TAG]) begin
            tagMark <= 1'b1;
         end else if (changeOfFlow || (execute && tagMark)) begin
            tagMark <= 1'b0;
         end
         if (breakFire && !control[`CTL_TAG]) begin
            forceLatch <= 1'b1;
         end else if (instrDone) begin
            forceLatch <= 1'b0;
         end
         // Marked opcode or finished instruction hands over the break opcode
         substituteValid <= (execute && tagMark) || (instrDone && forceLatch);
         substituteOpcode <= backgroundModeEnable ? `BACKGROUND_ENTRY_OPCODE : `SOFTWARE_INTERRUPT_OPCODE;
         breakPending <= tagMark | forceLatch;
      end
   end

   // ----------------------------------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         compA <= 16'h0000;
         compB <= 16'h0000;
         control <= `CTL_RESET;
         triggerControl <= `TC_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            case (paddr)
               `OFF_COMP_A: prdata <= {16'h0000, compA};
               `OFF_COMP_B: prdata <= {16'h0000, compB};
               `OFF_FIFO_DATA: prdata <= {16'h0000, fifoOut};
               `OFF_CONTROL: prdata <= {24'h000000, control};
               `OFF_TRIGGER_CONTROL: prdata <= {24'h000000, triggerControl};
               `OFF_DEBUG_STATUS: prdata <= {24'h000000, compAHit, compBHit, runActive, 1'b0, fifoCount};
               default: pslverr <= 1'b1;
            endcase
         end
         if (apbAccess && pwrite) begin
            case (paddr)
               `OFF_COMP_A: compA <= pwdata[15:0];
               `OFF_COMP_B: compB <= pwdata[15:0];
               `OFF_CONTROL: control <= pwdata[7:0];
               // Unused bits 5:4 are not stored, so they always read 0
               `OFF_TRIGGER_CONTROL: triggerControl <= pwdata[7:0] & `TC_WRITE_MASK;
               default: control <= control;
            endcase
         end
         if (runActive && runEnd && !armStart) begin
            control[`CTL_ARM] <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ### test/debug_trigger_logic_asserts.sv
/*
 Checker for the debug trigger logic top-level ports.
 Assumes one clock domain and the register offsets of the shared header.
*/
`timescale 1ns/1ns
`default_nettype none
`include "debug_trigger_regs.vh"

module debug_trigger_logic_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // CPU side
   input wire logic execute,
   input wire logic instrDone,
   input wire logic backgroundModeEnable,
   input wire logic tagRequest,
   input wire logic forceRequest,
   input wire logic substituteValid,
   input wire logic [7:0] substituteOpcode,
   input wire logic breakPending,
   input wire logic runActive
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   wire logic ctlWr = psel && penable && pready && pwrite && paddr == `OFF_CONTROL;
   wire logic anyReq = tagRequest || forceRequest;

   property p_arm; ctlWr && pwdata[1:0] == 2'b11 |-> ##[1:2] runActive; endproperty
   a_arm: assert property (p_arm) else $error("arm write did not start a run");
   property p_stop; ctlWr && pwdata[1:0] != 2'b11 |-> ##[1:2] !runActive; endproperty
   a_stop: assert property (p_stop) else $error("run kept going after stop write");
   property p_req; anyReq |-> $past(runActive); endproperty
   a_req: assert property (p_req) else $error("break request outside a run");
   property p_onekind; tagRequest |-> !forceRequest; endproperty
   a_onekind: assert property (p_onekind) else $error("tag and force request together");
   property p_pend; anyReq |-> ##[0:1] breakPending; endproperty
   a_pend: assert property (p_pend) else $error("request not held as pending");
   property p_sub; substituteValid |-> $past(execute) || $past(instrDone); endproperty
   a_sub: assert property (p_sub) else $error("substitute without execute or completion");
   // A mark set by a request can be consumed before the pending flag shows it
   property p_subpend; substituteValid |-> $past(breakPending) || $past(anyReq); endproperty
   a_subpend: assert property (p_subpend) else $error("substitute without pending break");
   property p_opc;
      substituteValid |-> substituteOpcode ==
         ($past(backgroundModeEnable) ? `BACKGROUND_ENTRY_OPCODE : `SOFTWARE_INTERRUPT_OPCODE);
   endproperty
   a_opc: assert property (p_opc) else $error("wrong substitute opcode");
   property p_mode;
      psel && penable && pready && !pwrite && paddr == `OFF_TRIGGER_CONTROL |->
         prdata[31:8] == 24'h0 && prdata[5:4] == 2'b00;
   endproperty
   a_mode: assert property (p_mode) else $error("trigger control unused bits set");
endmodule

bind debug_trigger_logic debug_trigger_logic_asserts chk (.ref_clk, .arst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .execute, .instrDone, .backgroundModeEnable, .tagRequest,
   .forceRequest, .substituteValid, .substituteOpcode, .breakPending, .runActive);
`default_nettype wire

// ### test/cpu_bus_model.sv
/*
 CPU-side model: bus cycles and instruction queue pulses on call.
 Assumes calls start right after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none

module cpu_bus_model (
   // Clock
   input wire logic ref_clk,
   // Bus cycle
   output var logic busValid,
   output var logic busRead,
   output var logic [15:0] busAddr,
   output var logic [7:0] busData,
   output var logic opcodeFetch,
   output var logic changeOfFlow,
   // Queue
   output var logic execute,
   output var logic instrDone,
   output var logic [7:0] execOpcode
);
   initial begin
      {busValid, busRead, opcodeFetch, changeOfFlow, execute, instrDone} = 6'h00;
      busAddr = 16'h0000;
      busData = 8'h00;
      execOpcode = 8'h00;
   end

   // Released lines show the inverse so stale values never match
   task automatic busCycle(input logic [15:0] a, input logic [7:0] d, input logic rd, input logic fetch);
      busValid <= 1'b1;
      busAddr <= a;
      busData <= d;
      busRead <= rd;
      opcodeFetch <= fetch;
      @(posedge ref_clk);
      busValid <= 1'b0;
      opcodeFetch <= 1'b0;
      busAddr <= ~a;
      busData <= ~d;
      @(posedge ref_clk);
   endtask

   // Change-of-flow bus cycle; also flushes the opcode trackers
   task automatic flowCycle(input logic [15:0] a);
      changeOfFlow <= 1'b1;
      busValid <= 1'b1;
      busAddr <= a;
      @(posedge ref_clk);
      changeOfFlow <= 1'b0;
      busValid <= 1'b0;
      busAddr <= ~a;
      @(posedge ref_clk);
   endtask

   task automatic pulse(input logic done);
      if (done)
         instrDone <= 1'b1;
      else
         execute <= 1'b1;
      @(posedge ref_clk);
      instrDone <= 1'b0;
      execute <= 1'b0;
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
/*
 Testbench: APB register access, per-mode bus probes, break and substitute checks.
 Assumes the CPU-side model in cpu_bus_model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "debug_trigger_regs.vh"

module testbench;
   logic refClk = 1'b0, arstN = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, background_entry_opcode = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, tagRequest, forceRequest, substituteValid, breakPending, runActive;
   wire logic busValid, busRead, opcodeFetch, changeOfFlow, execute, instrDone;
   wire logic [15:0] busAddr;
   wire logic [7:0] busData, execOpcode, substituteOpcode;
   int fail_count = 0, cmp_count = 0, reqCnt = 0, subCnt = 0, tagCnt = 0, n0;
   logic [7:0] subOp = 8'h00;
   localparam logic [15:0] compA = 16'h1000, compB = 16'h2055;
   // Entry: mode, expected hit, address, data
   logic [31:0] tbl [12] = '{32'h01100000, 32'h00100100, 32'h11205500, 32'h10300000, 32'h51100055,
      32'h50100054, 32'h61100054, 32'h60100055, 32'h71205500, 32'h70205600, 32'h810fff00, 32'h80100000};

   debug_trigger_logic uut (.ref_clk(refClk), .arst_n(arstN), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .busValid, .busRead, .busAddr, .busData, .opcodeFetch, .changeOfFlow,
      .execute, .instrDone, .execOpcode, .backgroundModeEnable(background_entry_opcode), .tagRequest, .forceRequest,
      .substituteValid, .substituteOpcode, .breakPending, .runActive);
   cpu_bus_model cpu (.ref_clk(refClk), .busValid, .busRead, .busAddr, .busData, .opcodeFetch,
      .changeOfFlow, .execute, .instrDone, .execOpcode);

   always #2 refClk = ~refClk;
   always @(posedge refClk) begin
      if (tagRequest === 1'b1 || forceRequest === 1'b1)
         reqCnt <= reqCnt + 1;
      if (tagRequest === 1'b1)
         tagCnt <= tagCnt + 1;
      if (substituteValid === 1'b1) begin
         subCnt <= subCnt + 1;
         subOp <= substituteOpcode;
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [31:0] exp, input logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge refClk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge refClk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fail_count++;
         $display("wrong value at %0t: no bus answer", $time);
         conclude();
      end else begin
         if (!wr)
            check(prdata & m, exp);
         check({31'h0, pslverr}, {31'h0, err});
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge refClk);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0, m, exp, err);
   endtask

   task automatic arm(input logic [7:0] ctl, input logic [7:0] tc);
      wr(`OFF_TRIGGER_CONTROL, {24'h0, tc});
      wr(`OFF_CONTROL, {24'h0, ctl});
   endtask

   // Request is one cycle after the bus cycle; two spare edges let it land
   task automatic probe(input logic [15:0] a, input logic [7:0] d, input logic dir, input logic exp);
      n0 = reqCnt;
      cpu.busCycle(a, d, dir, 1'b0);
      repeat (2) @(posedge refClk);
      check({31'h0, reqCnt != n0}, {31'h0, exp});
   endtask

   // Counter is read after the wait, not when the task is called
   task automatic waitCheck(input int base, input logic sub, input logic exp);
      repeat (3) @(posedge refClk);
      check({31'h0, (sub ? subCnt : reqCnt) != base}, {31'h0, exp});
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge refClk);
      arstN <= 1'b1;
      @(posedge refClk);
      rd(`OFF_CONTROL, 32'hffffffff, 32'h0, 1'b0);
      rd(`OFF_TRIGGER_CONTROL, 32'hffffffff, 32'h0, 1'b0);
      rd(12'h020, 32'hffffffff, 32'h0, 1'b1);
      wr(`OFF_COMP_A, {16'h0, compA});
      wr(`OFF_COMP_B, {16'h0, compB});
      for (int i = 0; i < 12; i++) begin
         arm(8'h0b, {4'h7, tbl[i][31:28]});
         probe(tbl[i][23:8], tbl[i][7:0], 1'b1, tbl[i][24]);
      end
      rd(`OFF_TRIGGER_CONTROL, 32'hffffffff, 32'h48, 1'b0);
      arm(8'h3b, 8'h40);
      probe(compA, 8'h00, 1'b0, 1'b0);
      probe(compA, 8'h00, 1'b1, 1'b1);
      arm(8'h0b, 8'h42);
      probe(compB, 8'h00, 1'b1, 1'b0);
      probe(compA, 8'h00, 1'b1, 1'b0);
      repeat (5) @(posedge refClk);
      probe(compB, 8'h00, 1'b1, 1'b1);
      arm(8'h0b, 8'h40);
      wr(`OFF_CONTROL, 32'h01);
      rd(`OFF_DEBUG_STATUS, 32'h20, 32'h0, 1'b0);
      probe(compA, 8'h00, 1'b1, 1'b0);
      arm(8'h0b, 8'h40);
      wr(`OFF_CONTROL, 32'h02);
      rd(`OFF_DEBUG_STATUS, 32'h20, 32'h0, 1'b0);
      arm(8'h03, 8'h03);
      for (int i = 0; i < 9; i++)
         cpu.busCycle(compB, {4'h1, i[3:0]}, 1'b0, 1'b0);
      rd(`OFF_DEBUG_STATUS, 32'h2f, 32'h08, 1'b0);
      rd(`OFF_FIFO_DATA, 32'hff, 32'h10, 1'b0);
      arm(8'h03, 8'h03);
      rd(`OFF_DEBUG_STATUS, 32'hef, 32'h20, 1'b0);
      arm(8'h03, 8'h04);
      cpu.busCycle(compB, 8'h21, 1'b0, 1'b0);
      cpu.busCycle(compA, 8'h22, 1'b0, 1'b0);
      cpu.busCycle(compB, 8'h23, 1'b0, 1'b0);
      cpu.busCycle(compB, 8'h24, 1'b0, 1'b0);
      rd(`OFF_DEBUG_STATUS, 32'h0f, 32'h02, 1'b0);
      arm(8'h03, 8'h00);
      cpu.flowCycle(16'h0100);
      cpu.flowCycle(16'h0200);
      cpu.busCycle(compA, 8'h00, 1'b1, 1'b0);
      rd(`OFF_DEBUG_STATUS, 32'h2f, 32'h02, 1'b0);
      rd(`OFF_FIFO_DATA, 32'hffff, 32'h0100, 1'b0);
      arm(8'h03, 8'h40);
      cpu.flowCycle(16'h0300);
      cpu.busCycle(compA, 8'h00, 1'b1, 1'b0);
      cpu.flowCycle(16'h0400);
      rd(`OFF_DEBUG_STATUS, 32'h2f, 32'h21, 1'b0);
      rd(`OFF_FIFO_DATA, 32'hffff, 32'h0400, 1'b0);
      cpu.pulse(1'b1);
      arm(8'h0b, 8'h40);
      probe(compA, 8'h00, 1'b1, 1'b1);
      waitCheck(subCnt, 1'b1, 1'b0);
      n0 = subCnt;
      cpu.pulse(1'b1);
      waitCheck(n0, 1'b1, 1'b1);
      check({24'h0, subOp}, {24'h0, `SOFTWARE_INTERRUPT_OPCODE});
      background_entry_opcode <= 1'b1;
      arm(8'h0f, 8'h40);
      n0 = reqCnt;
      cpu.busCycle(compA, 8'h00, 1'b1, 1'b1);
      waitCheck(n0, 1'b0, 1'b1);
      check(tagCnt, 32'd1);
      n0 = subCnt;
      cpu.pulse(1'b0);
      waitCheck(n0, 1'b1, 1'b1);
      check({24'h0, subOp}, {24'h0, `BACKGROUND_ENTRY_OPCODE});
      arm(8'h0b, 8'hc0);
      n0 = reqCnt;
      cpu.busCycle(compA, 8'h00, 1'b1, 1'b1);
      waitCheck(n0, 1'b0, 1'b0);
      cpu.pulse(1'b0);
      waitCheck(n0, 1'b0, 1'b1);
      arm(8'h0f, 8'h45);
      probe(compA, 8'h00, 1'b1, 1'b1);
      conclude();
   end
endmodule
`default_nettype wire
